/* shared/pwh_pkg.sv */
// Package for the pseudowire header and control word block
//
// Overview of operation
// - Metro Ethernet mode: bundle goes into circuit_identifier; receive takes bundle from it.
// - L2TPv3 over IPv4: protocol field 0x73 sent and recognised on receive.
// - L2TPv3 over IPv6: next-header 0x73 sent and recognised on receive.
// - Session identifier is 32 bits holding bundle; value zero never names a bundle.
// - Optional 32 or 64 bit cookie follows session; receiver checks it.
// - Reserved control word bits are always sent as zero.
// - Local-failure flag follows per-port loss bit from software.
// - Remote-failure flag follows per-bundle transmit remote-failure bit.
// - Remote failure set after configured missing packets; cleared when packets return.
// - Two-bit defect modifier follows per-port configuration field.
// - Fragment code: 00 whole, 01 first, 10 last, 11 intermediate.
// - Length field filled only when total below 64 bytes, else zero.
// - Per-bundle sequence counter increments per packet and wraps.
// - Sequence counter start value is random, not a fixed constant.
// - Receiver uses sequence numbers to detect loss and flag out-of-order packets.
// - HDLC sequence modes: zero after the bundle's first packet, wrap increment, wrap increment skipping zero.
// - OAM sequence independent: queries increment, replies copy received value.
// - RTP sequence number equals control word sequence number.
`default_nettype none
package pwh_pkg;
  // ******************************************************
  // Register map (APB byte addresses)
  // ******************************************************
  localparam logic [11:0] ADR_CTRL    = 12'h000;
  localparam logic [11:0] ADR_PORT    = 12'h004;
  localparam logic [11:0] ADR_BSEL    = 12'h008;
  localparam logic [11:0] ADR_BCFG    = 12'h00c;
  localparam logic [11:0] ADR_COOKLO  = 12'h010;
  localparam logic [11:0] ADR_COOKHI  = 12'h014;
  localparam logic [11:0] ADR_STAT    = 12'h018;
  localparam logic [11:0] ADR_MASK    = 12'h01c;
  localparam logic [11:0] ADR_BSTAT   = 12'h020;
  localparam logic [11:0] ADR_SEED    = 12'h024;
  // ******************************************************
  // Encodings and constants
  // ******************************************************
  localparam logic [7:0]  L2TP_PROTO  = 8'h73;
  localparam logic [31:0] SESS_RSVD   = 32'h0000_0000;
  localparam logic [6:0]  LEN_LIMIT   = 7'h40;
  localparam logic [3:0]  RES_ZERO    = 4'h0;
  localparam logic [15:0] SEED_RST    = 16'hace1;
  localparam logic [15:0] LFSR_TAPS   = 16'hb400;
  localparam logic [7:0]  MISS_RST    = 8'h08;
  localparam logic [31:0] STAT_RST    = 32'h0000_0000;
  localparam int          ST_RFAIL    = 0;
  localparam int          ST_RCLR     = 1;
  localparam int          ST_LOSS     = 2;
  localparam int          ST_REJECT   = 3;
  localparam int          NUM_EV      = 4;

  typedef enum logic [1:0] {
    PWH_ENC_MEF = 2'h0, PWH_ENC_L2V4 = 2'h1, PWH_ENC_L2V6 = 2'h2, PWH_ENC_OTHER = 2'h3
  } pwh_enc_t;
  typedef enum logic [1:0] {
    PWH_SQ_NORMAL = 2'h0, PWH_SQ_ZERO = 2'h1, PWH_SQ_WRAP = 2'h2, PWH_SQ_SKIPZ = 2'h3
  } pwh_sqmode_t;
  typedef enum logic [1:0] {
    PWH_FRG_WHOLE = 2'h0, PWH_FRG_FIRST = 2'h1, PWH_FRG_LAST = 2'h2, PWH_FRG_MID = 2'h3
  } pwh_frg_t;
  typedef enum logic [2:0] {
    PWH_PK_DATA = 3'h1, PWH_PK_QUERY = 3'h2, PWH_PK_REPLY = 3'h4
  } pwh_pkind_t;

  // Transmit request from payload side
  typedef struct packed {
    logic [5:0]  bundle;
    pwh_pkind_t  kind;
    pwh_frg_t    fragment_position;
    logic [7:0]  len_bytes;
    logic        udp_ip;
    logic [15:0] oam_seq;
  } pwh_txreq_t;
  // Built transmit header
  typedef struct packed {
    logic [7:0]  proto;
    logic [31:0] circuit_identifier;
    logic [63:0] cookie;
    logic [1:0]  cookie_len;
    logic [31:0] ctrl_word;
    logic [15:0] rtp_seq;
  } pwh_txhdr_t;
  // Received header fields
  typedef struct packed {
    logic [7:0]  proto;
    logic [31:0] circuit_identifier;
    logic [63:0] cookie;
    logic [31:0] ctrl_word;
  } pwh_rxhdr_t;
  // Receive result
  typedef struct packed {
    logic        accept;
    logic [5:0]  bundle;
    logic        lost;
    logic        reorder;
    logic [15:0] seq;
  } pwh_rxres_t;
endpackage
`default_nettype wire

/* verilog/pwh_core.sv */
// Pseudowire header and control word builder and checker with APB registers
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`default_nettype none
module pwh_core #(
  parameter int NB = 64
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  output var  logic              irq,
  input  wire logic              tx_valid,
  input  wire pwh_pkg::pwh_txreq_t tx_req,
  output var  logic              hdr_valid,
  output var  pwh_pkg::pwh_txhdr_t hdr_out,
  input  wire logic              rx_valid,
  input  wire pwh_pkg::pwh_rxhdr_t rx_hdr,
  output var  logic              res_valid,
  output var  pwh_pkg::pwh_rxres_t res_out,
  input  wire logic              miss_tick
);
  localparam int BW = $clog2(NB);
  localparam logic [15:0] SEQ_HALF = 16'h8000;

  // ******************************************************
  // Configuration, status and state registers
  // ******************************************************
  pwh_pkg::pwh_enc_t    enc_ff;
  logic [1:0]           cook_ff;       // 0 none, 1 32-bit, 2 64-bit
  logic                 loss_ff;
  logic [1:0]           defmod_ff;
  logic [BW-1:0]        bsel_ff;
  logic [63:0]          cookie_ff;
  logic [NB-1:0]        txr_ff;
  logic [NB-1:0]        rfail_ff;
  pwh_pkg::pwh_sqmode_t sqm_ff [NB];
  logic [7:0]           miss_lim_ff;
  localparam int NUM_EV_W = pwh_pkg::NUM_EV;
  logic [15:0]          lfsr_ff;
  logic [NUM_EV_W-1:0]  stat_ff;
  logic [NUM_EV_W-1:0]  mask_ff;
  logic [15:0]          txseq_ff [NB];
  logic [15:0]          rxexp_ff [NB];
  logic [7:0]           miss_ff  [NB];
  logic [NB-1:0]        seen_ff;
  logic [NB-1:0]        rxseen_ff;
  logic [15:0]          oamseq_ff;

  // APB decode
  logic wr_acc;
  logic rd_acc;
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;

  function automatic logic known_addr(input logic [11:0] a);
    known_addr = (a <= pwh_pkg::ADR_SEED) && (a[1:0] == 2'h0);
  endfunction

  // Random number source for seeding sequence counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_ff <= pwh_pkg::SEED_RST;
    end else if (wr_acc && paddr == pwh_pkg::ADR_SEED) begin
      lfsr_ff <= pwdata[15:0] ^ lfsr_ff;    // Software mixes in entropy
    end else begin
      lfsr_ff <= {1'b0, lfsr_ff[15:1]} ^ (lfsr_ff[0] ? pwh_pkg::LFSR_TAPS : 16'h0000);
    end
  end

  // Global and per-port configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_ff      <= pwh_pkg::PWH_ENC_MEF;
      cook_ff     <= 2'h0;
      loss_ff     <= 1'b0;
      defmod_ff   <= 2'h0;
      bsel_ff     <= '0;
      cookie_ff   <= 64'h0;
      miss_lim_ff <= pwh_pkg::MISS_RST;
      mask_ff     <= '0;
    end else if (wr_acc) begin
      if (paddr == pwh_pkg::ADR_CTRL) begin
        enc_ff      <= pwh_pkg::pwh_enc_t'(pwdata[1:0]);
        cook_ff     <= pwdata[3:2];
        miss_lim_ff <= pwdata[15:8];
      end else if (paddr == pwh_pkg::ADR_PORT) begin
        loss_ff   <= pwdata[0];
        defmod_ff <= pwdata[2:1];
      end else if (paddr == pwh_pkg::ADR_BSEL) begin
        bsel_ff <= pwdata[BW-1:0];
      end else if (paddr == pwh_pkg::ADR_COOKLO) begin
        cookie_ff[31:0] <= pwdata;
      end else if (paddr == pwh_pkg::ADR_COOKHI) begin
        cookie_ff[63:32] <= pwdata;
      end else if (paddr == pwh_pkg::ADR_MASK) begin
        mask_ff <= pwdata[NUM_EV_W-1:0];
      end
    end
  end

  // Per-bundle configuration: tx remote-failure bit and sequence mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txr_ff <= '0;
      for (int i = 0; i < NB; i++) begin
        sqm_ff[i] <= pwh_pkg::PWH_SQ_NORMAL;
      end
    end else if (wr_acc && paddr == pwh_pkg::ADR_BCFG) begin
      txr_ff[bsel_ff] <= pwdata[0];
      sqm_ff[bsel_ff] <= pwh_pkg::pwh_sqmode_t'(pwdata[2:1]);
    end
  end

  // ******************************************************
  // Transmit header construction
  // ******************************************************
  pwh_pkg::pwh_txreq_t q;
  logic [15:0] cur_seq;
  logic [15:0] nxt_seq;
  logic [15:0] inc_seq;
  logic [5:0]  len_fld;
  logic [31:0] sess_id;
  logic [15:0] tx_seq_sel;
  assign q       = tx_req;
  assign cur_seq = txseq_ff[q.bundle[BW-1:0]];
  assign inc_seq = cur_seq + 16'h0001;

  // Next sequence value per HDLC sequencing mode
  always_comb begin
    case (sqm_ff[q.bundle[BW-1:0]])
      pwh_pkg::PWH_SQ_ZERO:  nxt_seq = 16'h0000;
      pwh_pkg::PWH_SQ_SKIPZ: nxt_seq = (inc_seq == 16'h0000) ? 16'h0001 : inc_seq;
      default:               nxt_seq = inc_seq;
    endcase
  end

  // Length only when short, and never for UDP/IP
  assign len_fld = (!q.udp_ip && q.len_bytes < {1'b0, pwh_pkg::LEN_LIMIT})
                 ? q.len_bytes[5:0] : 6'h00;
  // Bundle zero is remapped away from the reserved session value
  assign sess_id = {26'h0, q.bundle} + 32'h0000_0001;
  // OAM kinds number apart from data
  assign tx_seq_sel = (q.kind == pwh_pkg::PWH_PK_QUERY) ? oamseq_ff :
                      (q.kind == pwh_pkg::PWH_PK_REPLY) ? q.oam_seq :
                      (seen_ff[q.bundle[BW-1:0]] ? nxt_seq : lfsr_ff);

  // Per-bundle transmit counters, randomly seeded on the bundle's first data packet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NB; i++) begin
        txseq_ff[i] <= 16'h0000;
      end
      seen_ff   <= '0;
      oamseq_ff <= 16'h0000;
    end else begin
      if (tx_valid && q.kind == pwh_pkg::PWH_PK_DATA) begin
        if (!seen_ff[q.bundle[BW-1:0]]) begin
          txseq_ff[q.bundle[BW-1:0]] <= lfsr_ff;
          seen_ff[q.bundle[BW-1:0]]  <= 1'b1;
        end else begin
          txseq_ff[q.bundle[BW-1:0]] <= nxt_seq;
        end
      end
      if (tx_valid && q.kind == pwh_pkg::PWH_PK_QUERY) begin
        oamseq_ff <= oamseq_ff + 16'h0001;
      end
    end
  end

  // Header output register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hdr_valid <= 1'b0;
      hdr_out   <= '0;
    end else begin
      hdr_valid <= tx_valid;
      if (tx_valid) begin
        hdr_out.proto <= (enc_ff == pwh_pkg::PWH_ENC_L2V4 ||
                          enc_ff == pwh_pkg::PWH_ENC_L2V6) ? pwh_pkg::L2TP_PROTO : 8'h00;
        hdr_out.circuit_identifier <= (enc_ff == pwh_pkg::PWH_ENC_MEF)
                                    ? {26'h0, q.bundle} : sess_id;
        hdr_out.cookie     <= (cook_ff == 2'h1) ? {32'h0, cookie_ff[31:0]} :
                              (cook_ff == 2'h2) ? cookie_ff : 64'h0;
        hdr_out.cookie_len <= cook_ff;
        hdr_out.ctrl_word  <= {pwh_pkg::RES_ZERO,
                               loss_ff,
                               txr_ff[q.bundle[BW-1:0]],
                               defmod_ff,
                               q.fragment_position,
                               len_fld, tx_seq_sel};
        hdr_out.rtp_seq    <= tx_seq_sel;
      end
    end
  end

  // ******************************************************
  // Receive checking
  // ******************************************************
  logic        rx_l2;
  logic        rx_ok;
  logic [5:0]  rx_b;
  logic [15:0] rx_seq;
  logic        ck_ok;
  logic        rx_seen;
  logic [15:0] rx_gap;
  logic [NB-1:0] rx_hit;
  assign rx_l2  = (enc_ff == pwh_pkg::PWH_ENC_L2V4 || enc_ff == pwh_pkg::PWH_ENC_L2V6);
  assign rx_b   = (enc_ff == pwh_pkg::PWH_ENC_MEF) ? rx_hdr.circuit_identifier[5:0]
                : 6'(rx_hdr.circuit_identifier - 32'h0000_0001);
  assign ck_ok  = (cook_ff == 2'h0) ||
                  (cook_ff == 2'h1 && rx_hdr.cookie[31:0] == cookie_ff[31:0]) ||
                  (cook_ff == 2'h2 && rx_hdr.cookie == cookie_ff);
  assign rx_ok  = (!rx_l2 || (rx_hdr.proto == pwh_pkg::L2TP_PROTO
                  && rx_hdr.circuit_identifier != pwh_pkg::SESS_RSVD))
                  && ck_ok;
  assign rx_seq = rx_hdr.ctrl_word[15:0];

  // Bundle refreshed by an accepted packet
  function automatic logic [NB-1:0] miss_clr_any(input logic hit, input logic [BW-1:0] b);
    miss_clr_any    = '0;
    miss_clr_any[b] = hit;
  endfunction
  assign rx_seen = rxseen_ff[rx_b[BW-1:0]];
  assign rx_gap  = rx_seq - rxexp_ff[rx_b[BW-1:0]];
  assign rx_hit  = miss_clr_any(rx_valid & rx_ok, rx_b[BW-1:0]);

  // Loss and order detection against expected sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_valid <= 1'b0;
      res_out   <= '0;
      for (int i = 0; i < NB; i++) begin
        rxexp_ff[i] <= 16'h0000;
      end
      rxseen_ff <= '0;
    end else begin
      res_valid <= rx_valid;
      if (rx_valid) begin
        res_out.accept  <= rx_ok;
        res_out.bundle  <= rx_b;
        res_out.seq     <= rx_seq;
        res_out.lost    <= rx_ok && rx_seen && rx_gap != 16'h0000
                           && rx_gap < SEQ_HALF;
        res_out.reorder <= rx_ok && rx_seen && rx_gap >= SEQ_HALF;
        // First packet only sets the expectation
        if (rx_ok && (!rx_seen || rx_gap < SEQ_HALF)) begin
          rxexp_ff[rx_b[BW-1:0]]  <= rx_seq + 16'h0001;
          rxseen_ff[rx_b[BW-1:0]] <= 1'b1;
        end
      end
    end
  end

  // Missing packet counters drive remote failure per bundle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rfail_ff <= '0;
      for (int i = 0; i < NB; i++) begin
        miss_ff[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < NB; i++) begin
        if (rx_hit[i]) begin
          miss_ff[i]  <= 8'h00;
          rfail_ff[i] <= 1'b0;
        end else if (miss_tick && miss_ff[i] < miss_lim_ff) begin
          miss_ff[i] <= miss_ff[i] + 8'h01;
        end else if (miss_ff[i] >= miss_lim_ff) begin
          rfail_ff[i] <= 1'b1;
        end
      end
    end
  end

  // ******************************************************
  // Interrupt status, set wins over write-one clear
  // ******************************************************
  logic [NUM_EV_W-1:0] ev;
  assign ev = {rx_valid & ~rx_ok,
               res_valid & res_out.lost,
               |(rfail_ff & rx_hit),
               |rfail_ff};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_ff <= pwh_pkg::STAT_RST[NUM_EV_W-1:0];
    end else begin
      stat_ff <= (stat_ff & ~((wr_acc && paddr == pwh_pkg::ADR_STAT)
                 ? pwdata[NUM_EV_W-1:0] : '0)) | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_ff & mask_ff);
    end
  end

  // APB answer: one access cycle, zero wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~known_addr(paddr);
      if (psel && !penable && !pwrite) begin
        if (paddr == pwh_pkg::ADR_CTRL) begin
          prdata <= {16'h0, miss_lim_ff, 4'h0, cook_ff, enc_ff};
        end else if (paddr == pwh_pkg::ADR_PORT) begin
          prdata <= {29'h0, defmod_ff, loss_ff};
        end else if (paddr == pwh_pkg::ADR_BCFG) begin
          prdata <= {29'h0, sqm_ff[bsel_ff], txr_ff[bsel_ff]};
        end else if (paddr == pwh_pkg::ADR_STAT) begin
          prdata <= 32'(stat_ff);
        end else if (paddr == pwh_pkg::ADR_MASK) begin
          prdata <= 32'(mask_ff);
        end else if (paddr == pwh_pkg::ADR_BSTAT) begin
          prdata <= {15'h0, rfail_ff[bsel_ff], txseq_ff[bsel_ff]};
        end else if (paddr == pwh_pkg::ADR_SEED) begin
          prdata <= {16'h0, lfsr_ff};
        end else begin
          prdata <= 32'h0;
        end
      end
    end
  end

  // ******************************************************
  // Assertions
  // ******************************************************
  a_res_zero: assert property (@(posedge pclk) disable iff (!presetn)
    hdr_valid |-> hdr_out.ctrl_word[31:28] == 4'h0) else $error("reserved bits set");
  a_rtp_match: assert property (@(posedge pclk) disable iff (!presetn)
    hdr_valid |-> hdr_out.rtp_seq == hdr_out.ctrl_word[15:0]) else $error("rtp seq mismatch");
  a_l2_proto: assert property (@(posedge pclk) disable iff (!presetn)
    tx_valid && rx_l2 |=> hdr_out.proto == 8'h73) else $error("protocol not l2tp");
  a_sess_nz: assert property (@(posedge pclk) disable iff (!presetn)
    hdr_valid && rx_l2 |-> hdr_out.circuit_identifier != 32'h0) else $error("session zero");
  a_loss_flag: assert property (@(posedge pclk) disable iff (!presetn)
    tx_valid |=> hdr_out.ctrl_word[27] == $past(loss_ff)) else $error("loss flag wrong");
  a_len_big: assert property (@(posedge pclk) disable iff (!presetn)
    tx_valid && tx_req.len_bytes >= 8'h40 |=> hdr_out.ctrl_word[21:16] == 6'h0)
    else $error("length not zero");
  a_seq_zero: assert property (@(posedge pclk) disable iff (!presetn)
    tx_valid && tx_req.kind == pwh_pkg::PWH_PK_DATA && seen_ff[tx_req.bundle[BW-1:0]]
    && sqm_ff[tx_req.bundle[BW-1:0]] == pwh_pkg::PWH_SQ_ZERO |=> hdr_out.ctrl_word[15:0] == 16'h0)
    else $error("seq not zero");
  a_reply_copy: assert property (@(posedge pclk) disable iff (!presetn)
    tx_valid && tx_req.kind == pwh_pkg::PWH_PK_REPLY |=> hdr_out.rtp_seq == $past(tx_req.oam_seq))
    else $error("reply seq changed");
  a_rf_clear: assert property (@(posedge pclk) disable iff (!presetn)
    rx_valid && rx_ok |=> !rfail_ff[$past(rx_b[BW-1:0])]) else $error("rfail not cleared");
  a_first_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    rx_valid && rx_ok && !rx_seen |=> !res_out.lost && !res_out.reorder)
    else $error("first packet flagged");

  sequence s_query_sent;
    tx_valid && tx_req.kind == pwh_pkg::PWH_PK_QUERY;
  endsequence
  a_query_step: assert property (@(posedge pclk) disable iff (!presetn)
    s_query_sent |=> oamseq_ff == $past(oamseq_ff) + 16'h0001)
    else $error("query seq not stepped");
endmodule
`default_nettype wire

/* bench/pwh_remote_end.sv */
// Remote pseudowire endpoint model that loops sent headers back
`default_nettype none
module pwh_remote_end (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                hdr_valid,
  input  wire pwh_pkg::pwh_txhdr_t hdr_out,
  input  wire logic                drop,
  input  wire logic                bad_cookie,
  input  wire logic [3:0]          delay,
  output var  logic                rx_valid,
  output var  pwh_pkg::pwh_rxhdr_t rx_hdr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******************************************
  // Frame hold and return
  // ******************************************
  pwh_pkg::pwh_rxhdr_t held_ff;
  logic [3:0]          cnt_ff;
  logic                busy_ff;
  // One frame in flight; idle lines toggle so stale values never pass
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff  <= 1'b0;
      cnt_ff   <= 4'h0;
      held_ff  <= '0;
      rx_valid <= 1'b0;
      rx_hdr   <= '0;
    end else begin
      rx_valid <= 1'b0;
      rx_hdr   <= ~rx_hdr;
      if (hdr_valid && !drop) begin
        busy_ff <= 1'b1;
        cnt_ff  <= delay;
        // Cookie echoed as sent unless the bench asks for a corrupt one
        held_ff <= {hdr_out.proto, hdr_out.circuit_identifier,
                    hdr_out.cookie ^ {64{bad_cookie}}, hdr_out.ctrl_word};
      end else if (busy_ff && cnt_ff != 4'h0) begin
        cnt_ff <= cnt_ff - 4'h1;
      end else if (busy_ff) begin
        busy_ff  <= 1'b0;
        rx_valid <= 1'b1;
        rx_hdr   <= held_ff;
      end
    end
  end
endmodule
`default_nettype wire

/* bench/pseudowire_header_control_word_tb_top.sv */
// Self-checking bench for the pseudowire header and control word block
`default_nettype none
module pseudowire_header_control_word_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ******************************************
  // Signals and instances
  // ******************************************
  localparam logic [2:0] DAT = pwh_pkg::PWH_PK_DATA;
  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, rd;
  logic                tx_valid, hdr_valid, rx_valid, res_valid, miss_tick;
  logic                drop, bad, err;
  logic [3:0]          delay;
  pwh_pkg::pwh_txreq_t tx_req;
  pwh_pkg::pwh_txhdr_t hdr_out, h;
  pwh_pkg::pwh_rxhdr_t rx_hdr;
  pwh_pkg::pwh_rxres_t res_out, r;
  int                  errors, checked, cyc;
  logic [15:0]         s;

  pwh_core pwh_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .tx_valid(tx_valid), .tx_req(tx_req),
    .hdr_valid(hdr_valid), .hdr_out(hdr_out), .rx_valid(rx_valid), .rx_hdr(rx_hdr),
    .res_valid(res_valid), .res_out(res_out), .miss_tick(miss_tick));
  pwh_remote_end pwh_remote_end_inst (.pclk(pclk), .presetn(presetn),
    .hdr_valid(hdr_valid), .hdr_out(hdr_out), .drop(drop), .bad_cookie(bad),
    .delay(delay), .rx_valid(rx_valid), .rx_hdr(rx_hdr));

  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ******************************************
  // Shared tasks
  // ******************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // One APB transfer; waits for pready, bounded by the cycle ceiling
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Send one request, take the header, then the looped-back result
  task automatic send(input logic [5:0] b, input logic [2:0] k, input logic [1:0] f,
                      input logic [7:0] l, input logic [15:0] o);
    int n;
    @(posedge pclk);
    tx_valid <= 1'b1;
    tx_req   <= '{b, pwh_pkg::pwh_pkind_t'(k), pwh_pkg::pwh_frg_t'(f), l, 1'b0, o};
    @(posedge pclk);
    tx_valid <= 1'b0;
    @(negedge pclk);
    chk(hdr_valid, 1'b1, "no header");
    h = hdr_out;
    n = 0;
    while (!drop && res_valid !== 1'b1 && n < 40) begin
      @(negedge pclk);
      n++;
    end
    r = res_out;
    if (!drop) chk(res_valid, 1'b1, "no result");
    @(posedge pclk);
  endtask
  task automatic tick();
    @(posedge pclk);
    miss_tick <= 1'b1;
    @(posedge pclk);
    miss_tick <= 1'b0;
  endtask
  task automatic wrap_up();
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ******************************************
  // Scenarios
  // ******************************************
  task automatic t_encap();
    apb(1'b1, pwh_pkg::ADR_CTRL, 32'h0000_0801);
    send(6'h0, DAT, 2'h0, 8'h10, 16'h0);
    chk(h.proto, pwh_pkg::L2TP_PROTO, "v4 protocol");
    chk(h.circuit_identifier, 32'h1, "session of bundle 0");
    chk(r.accept, 1'b1, "v4 accept");
    chk(r.bundle, 6'h0, "v4 bundle");
    apb(1'b1, pwh_pkg::ADR_CTRL, 32'h0000_0802);
    send(6'h3f, DAT, 2'h0, 8'h10, 16'h0);
    chk(h.proto, pwh_pkg::L2TP_PROTO, "v6 next header");
    chk(h.circuit_identifier, 32'h40, "top session");
    chk(r.accept, 1'b1, "v6 accept");
    apb(1'b1, pwh_pkg::ADR_CTRL, 32'h0000_0800);
    send(6'h9, DAT, 2'h0, 8'h10, 16'h0);
    chk(h.circuit_identifier, 32'h9, "circuit id");
    chk(r.bundle, 6'h9, "rx bundle");
  endtask
  task automatic t_cw();
    apb(1'b1, pwh_pkg::ADR_PORT, 32'h5);
    apb(1'b1, pwh_pkg::ADR_BSEL, 32'h3);
    apb(1'b1, pwh_pkg::ADR_BCFG, 32'h1);
    for (int f = 0; f < 4; f++) begin
      send(6'h3, DAT, f[1:0], 8'h3f, 16'h0);
      chk(h.ctrl_word[31:28], pwh_pkg::RES_ZERO, "pad bits");
      chk(h.ctrl_word[27:24], 4'he, "flags");
      chk(h.ctrl_word[23:22], f, "fragment");
      chk(h.ctrl_word[21:16], 6'h3f, "length 63");
    end
    apb(1'b1, pwh_pkg::ADR_PORT, 32'h0);
    apb(1'b1, pwh_pkg::ADR_BCFG, 32'h0);
    send(6'h3, DAT, 2'h0, 8'h40, 16'h0);
    chk(h.ctrl_word[27:24], 4'h0, "flags cleared");
    chk(h.ctrl_word[21:16], 6'h0, "length 64");
  endtask
  task automatic t_seq();
    send(6'h3, DAT, 2'h0, 8'h10, 16'h0);
    s = h.ctrl_word[15:0];
    send(6'h4, DAT, 2'h0, 8'h10, 16'h0);
    send(6'h3, DAT, 2'h0, 8'h10, 16'h0);
    chk(h.ctrl_word[15:0], 16'(s + 16'h1), "per-bundle step");
    chk(h.rtp_seq, h.ctrl_word[15:0], "rtp copy");
    apb(1'b1, pwh_pkg::ADR_BCFG, 32'h2);
    send(6'h3, DAT, 2'h0, 8'h10, 16'h0);
    chk(h.ctrl_word[15:0], 16'h0, "zero mode");
    apb(1'b1, pwh_pkg::ADR_BCFG, 32'h4);
    send(6'h3, DAT, 2'h0, 8'h10, 16'h0);
    s = h.ctrl_word[15:0];
    send(6'h3, DAT, 2'h0, 8'h10, 16'h0);
    chk(h.ctrl_word[15:0], 16'(s + 16'h1), "wrap mode");
    apb(1'b1, pwh_pkg::ADR_BCFG, 32'h6);
    send(6'h3, DAT, 2'h0, 8'h10, 16'h0);
    chk(h.ctrl_word[15:0] == 16'h0, 1'b0, "skip zero mode");
    apb(1'b1, pwh_pkg::ADR_BCFG, 32'h0);
    send(6'h3, DAT, 2'h0, 8'h10, 16'h0);
    s = h.ctrl_word[15:0];
    send(6'h3, pwh_pkg::PWH_PK_QUERY, 2'h0, 8'h10, 16'h1233);
    send(6'h3, pwh_pkg::PWH_PK_REPLY, 2'h0, 8'h10, 16'h1234);
    chk(h.ctrl_word[15:0], 16'h1234, "reply copy");
    send(6'h3, DAT, 2'h0, 8'h10, 16'h0);
    chk(h.ctrl_word[15:0], 16'(s + 16'h1), "data apart from oam");
  endtask
  // Cookie reject raises a masked sticky event; dropped frame shows as loss
  task automatic t_rx();
    apb(1'b1, pwh_pkg::ADR_STAT, 32'hf);
    apb(1'b1, pwh_pkg::ADR_MASK, 32'h8);
    apb(1'b1, pwh_pkg::ADR_COOKLO, 32'h5a5a_0f0f);
    apb(1'b1, pwh_pkg::ADR_CTRL, 32'h0000_0805);
    for (int m = 1; m >= 0; m--) begin
      bad <= 1'b1;
      send(6'h3, DAT, 2'h0, 8'h10, 16'h0);
      bad <= 1'b0;
      chk(r.accept, 1'b0, "cookie mismatch");
      apb(1'b0, pwh_pkg::ADR_STAT, 32'h0);
      chk(rd[pwh_pkg::ST_REJECT], 1'b1, "reject flag");
      chk(irq, m[0], "irq follows mask");
      apb(1'b1, pwh_pkg::ADR_STAT, 32'hf);
      repeat (2) @(negedge pclk);
      chk(irq, 1'b0, "irq cleared");
      apb(1'b1, pwh_pkg::ADR_MASK, 32'h0);
    end
    send(6'h5, DAT, 2'h0, 8'h10, 16'h0);
    chk(r.accept, 1'b1, "cookie match");
    delay <= 4'h5;
    drop  <= 1'b1;
    send(6'h5, DAT, 2'h0, 8'h10, 16'h0);
    drop <= 1'b0;
    send(6'h5, DAT, 2'h0, 8'h10, 16'h0);
    chk(r.lost, 1'b1, "gap detected");
    delay <= 4'h0;
  endtask
  task automatic t_rfail();
    apb(1'b1, pwh_pkg::ADR_CTRL, 32'h0000_0301);
    apb(1'b1, pwh_pkg::ADR_BSEL, 32'h3);
    repeat (2) tick();
    apb(1'b0, pwh_pkg::ADR_BSTAT, 32'h0);
    chk(rd[16], 1'b0, "two misses");
    tick();
    apb(1'b0, pwh_pkg::ADR_BSTAT, 32'h0);
    chk(rd[16], 1'b1, "limit reached");
    send(6'h3, DAT, 2'h0, 8'h10, 16'h0);
    apb(1'b0, pwh_pkg::ADR_BSTAT, 32'h0);
    chk(rd[16], 1'b0, "packets back");
    apb(1'b0, 12'h100, 32'h0);
    chk(err, 1'b1, "unmapped refused");
  endtask
  // ******************************************
  // Main sequence and hang guard
  // ******************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, tx_valid} = '0;
    {miss_tick, drop, bad, delay, presetn, errors, checked} = '0;
    tx_req = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, pwh_pkg::ADR_STAT, 32'h0);
    chk(rd, pwh_pkg::STAT_RST, "status reset");
    t_encap();
    t_cw();
    t_seq();
    t_rx();
    t_rfail();
    wrap_up();
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end
endmodule
`default_nettype wire
